// File: core/spb_top.sv
/*
 Serial port mode decode and SPI master shift engine, with a write FIFO
 and the UART baud source. Assumes all inputs synchronous to clock_i and
 one pin-level resolver outside that uses the output enables.
*/
`timescale 1ns/1ps
`default_nettype none
module spb_top (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic mode_select_high_i,
   input wire logic mode_select_mid_i,
   input wire logic mode_select_low_i,
   input wire logic shift_speed_select_i,
   input wire logic bit_order_select_i,
   input wire logic tx_latch_level_i,
   input wire logic buf_wr_i,
   input wire logic [7:0] buf_wr_data_i,
   input wire logic flag_clear_i,
   input wire logic master_in_pin_i,
   input wire spb_pkg::spb_baud_cfg_s baud_cfg_i,
   input wire logic second_port_baud_tick_i,
   output logic buf_wr_ready_o,
   output logic [7:0] serial_buffer_o,
   output logic transmit_done_flag_o,
   output logic receive_done_flag_o,
   output logic [2:0] mode_o,
   output logic mode_reserved_o,
   output logic busy_o,
   output logic port_tx_pin_o,
   output logic port_tx_pin_oe_o,
   output logic port_rx_pin_o,
   output logic port_rx_pin_oe_o,
   output logic uart_baud_tick_o
);
   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      spb_pkg::spb_state_e st;
      spb_pkg::spb_mode_e mode;
      logic spi;
      logic rsv;
      logic [7:0] sh;
      logic [3:0] bits;
      logic [3:0] tick;
      logic [3:0] half;
      logic lsb;
      logic phase;
      logic sck;
      logic mosi;
      logic oe;
      logic [7:0] rx_byte;
      logic tdone;
      logic rdone;
      logic busy;
   } spb_top_s;

   spb_top_s s_ff, nxt_s;
   logic [2:0] code;
   logic fifo_out_valid, fifo_out_ready;
   logic [7:0] fifo_out_data;

   assign code = {mode_select_high_i, mode_select_mid_i, mode_select_low_i};

   ////////////////////////////////////////////////////////////////////////////
   // Write FIFO and baud source
   spb_fifo #(
      .W(spb_pkg::DATA_W),
      .D(spb_pkg::FIFO_DEPTH)
   ) u_fifo (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .in_valid_i(buf_wr_i),
      .in_data_i(buf_wr_data_i),
      .in_ready_o(buf_wr_ready_o),
      .out_valid_o(fifo_out_valid),
      .out_data_o(fifo_out_data),
      .out_ready_i(fifo_out_ready)
   );

   spb_baud u_baud (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .cfg_i(baud_cfg_i),
      .second_port_baud_tick_i(second_port_baud_tick_i),
      .baud_tick_o(uart_baud_tick_o)
   );

   // Engine takes one byte only when idle
   assign fifo_out_ready = (s_ff.st == spb_pkg::SPB_IDLE) && s_ff.spi;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      nxt_s = s_ff;
      nxt_s.mode = spb_pkg::spb_mode_e'(code);
      nxt_s.spi = (code == spb_pkg::SPB_MODE_SPI);
      nxt_s.rsv = (code >= spb_pkg::MODE_RSV_MIN);
      // No select output; software uses a port pin
      nxt_s.oe = nxt_s.spi;
      nxt_s.tdone = s_ff.tdone & ~flag_clear_i;
      nxt_s.rdone = s_ff.rdone & ~flag_clear_i;
      unique case (s_ff.st)
         spb_pkg::SPB_IDLE: begin
            nxt_s.sck = tx_latch_level_i;
            if (s_ff.spi && fifo_out_valid) begin
               nxt_s.sh = fifo_out_data;
               nxt_s.half = shift_speed_select_i ? spb_pkg::SPI_HALF_FAST
                                                 : spb_pkg::SPI_HALF_SLOW;
               nxt_s.lsb = bit_order_select_i;
               nxt_s.bits = 4'h0;
               nxt_s.st = spb_pkg::SPB_LOAD;
            end
         end
         spb_pkg::SPB_LOAD: begin
            nxt_s.mosi = s_ff.lsb ? s_ff.sh[0] : s_ff.sh[7];
            nxt_s.tick = s_ff.half - 4'h1;
            nxt_s.phase = 1'b0;
            nxt_s.st = spb_pkg::SPB_SHIFT;
         end
         spb_pkg::SPB_SHIFT: begin
            if (s_ff.tick != 4'h0) begin
               nxt_s.tick = s_ff.tick - 4'h1;
            end else begin
               nxt_s.tick = s_ff.half - 4'h1;
               if (!s_ff.phase) begin
                  nxt_s.sck = ~tx_latch_level_i;
                  nxt_s.sh = s_ff.lsb ? {master_in_pin_i, s_ff.sh[7:1]}
                                      : {s_ff.sh[6:0], master_in_pin_i};
                  nxt_s.bits = s_ff.bits + 4'h1;
                  nxt_s.phase = 1'b1;
               end else begin
                  nxt_s.sck = tx_latch_level_i;
                  nxt_s.phase = 1'b0;
                  if (s_ff.bits == spb_pkg::BITS_PER_XFER) begin
                     nxt_s.st = spb_pkg::SPB_DONE;
                  end else begin
                     nxt_s.mosi = s_ff.lsb ? s_ff.sh[0] : s_ff.sh[7];
                  end
               end
            end
         end
         spb_pkg::SPB_DONE: begin
            nxt_s.rx_byte = s_ff.sh;
            nxt_s.tdone = 1'b1;
            nxt_s.st = spb_pkg::SPB_IDLE;
         end
      endcase
      if (!s_ff.spi && s_ff.st != spb_pkg::SPB_IDLE) begin
         nxt_s.st = spb_pkg::SPB_IDLE;
      end
      nxt_s.busy = nxt_s.st != spb_pkg::SPB_IDLE;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         s_ff <= '0;
         s_ff.lsb <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign serial_buffer_o = s_ff.rx_byte;
   assign transmit_done_flag_o = s_ff.tdone;
   assign receive_done_flag_o = s_ff.rdone;
   assign mode_o = s_ff.mode;
   assign mode_reserved_o = s_ff.rsv;
   assign busy_o = s_ff.busy;
   assign port_tx_pin_o = s_ff.sck;
   assign port_tx_pin_oe_o = s_ff.oe;
   assign port_rx_pin_o = s_ff.mosi;
   assign port_rx_pin_oe_o = s_ff.oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [4:0] gap_ff;
   logic [3:0] edges_ff;
   logic seen_ff;

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         gap_ff <= 5'h0;
         edges_ff <= 4'h0;
         seen_ff <= 1'b0;
      end else begin
         gap_ff <= (s_ff.sck != nxt_s.sck) ? 5'h1 : gap_ff + {4'h0, gap_ff != 5'h1f};
         seen_ff <= (s_ff.st == spb_pkg::SPB_SHIFT) && (seen_ff || (s_ff.sck != nxt_s.sck));
         if (s_ff.st == spb_pkg::SPB_LOAD) begin
            edges_ff <= 4'h0;
         end else if (s_ff.st == spb_pkg::SPB_SHIFT && !s_ff.phase && s_ff.tick == 4'h0) begin
            edges_ff <= edges_ff + 4'h1;
         end
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);

   mode_spi_a: assert property (##1 (s_ff.spi == ($past(code) == 3'h4)))
      else $error("spi mode decode wrong");
   mode_reserved_a: assert property (##1 (mode_reserved_o == ($past(code) >= 3'h5)))
      else $error("reserved mode decode wrong");
   clk_period_a: assert property ((s_ff.st == spb_pkg::SPB_SHIFT) && seen_ff
      && (s_ff.sck != nxt_s.sck) |-> (gap_ff == {1'b0, s_ff.half}))
      else $error("shift clock half period wrong");
   pin_drive_a: assert property (##1 (port_tx_pin_oe_o == ($past(code) == 3'h4)
      && port_rx_pin_oe_o == port_tx_pin_oe_o))
      else $error("pin enables wrong");
   idle_level_a: assert property ((s_ff.st == spb_pkg::SPB_IDLE)
      && $past(s_ff.st == spb_pkg::SPB_IDLE)
      |-> (port_tx_pin_o == $past(tx_latch_level_i)))
      else $error("idle clock level wrong");
   write_start_a: assert property (buf_wr_i && buf_wr_ready_o && s_ff.spi
      && (code == 3'h4) && !busy_o && !fifo_out_valid |-> ##[1:5] busy_o)
      else $error("write did not start transfer");
   done_edges_a: assert property ($rose(transmit_done_flag_o) |-> (edges_ff == 4'h8))
      else $error("done flag not after eight edges");
   no_rx_flag_a: assert property (s_ff.spi |-> !receive_done_flag_o)
      else $error("receive flag set in spi mode");
   flag_sticky_a: assert property (transmit_done_flag_o && !flag_clear_i
      |=> transmit_done_flag_o)
      else $error("done flag lost without clear");

   xfer_done_c: cover property ($rose(transmit_done_flag_o));
   fast_xfer_c: cover property (busy_o && s_ff.half == spb_pkg::SPI_HALF_FAST
      ##1 $rose(transmit_done_flag_o));
   fifo_full_c: cover property (!buf_wr_ready_o);
   msb_first_c: cover property (busy_o && !s_ff.lsb);
endmodule
`default_nettype wire

// File: core/spb_pkg.sv
/*
 Constants, types and carriers for the serial port SPI master with baud sources.
 Assumes a single 50 MHz system clock and a synchronous active-high reset.
*/
package spb_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam logic [2:0] MODE_RSV_MIN = 3'h5;
   localparam logic [3:0] SPI_DIV_SLOW = 4'hc;
   localparam logic [3:0] SPI_DIV_FAST = 4'h4;
   localparam logic [3:0] SPI_HALF_SLOW = SPI_DIV_SLOW >> 1;
   localparam logic [3:0] SPI_HALF_FAST = SPI_DIV_FAST >> 1;
   localparam logic [3:0] BITS_PER_XFER = 4'h8;
   localparam logic [3:0] PRESCALE_SLOW = 4'hc;
   localparam logic [5:0] BAUD8_DIV = 6'h20;
   localparam logic [5:0] BAUD16_DIV = 6'h10;
   localparam logic [7:0] RELOAD8_TOP = 8'hff;
   localparam logic [15:0] RELOAD16_TOP = 16'hffff;

   typedef enum logic [2:0] {
      SPB_MODE_SHIFT = 3'h0,
      SPB_MODE_UART8 = 3'h1,
      SPB_MODE_UART9_FIXED = 3'h2,
      SPB_MODE_UART9_VAR = 3'h3,
      SPB_MODE_SPI = 3'h4,
      SPB_MODE_RSV5 = 3'h5,
      SPB_MODE_RSV6 = 3'h6,
      SPB_MODE_RSV7 = 3'h7
   } spb_mode_e;

   typedef enum logic [1:0] {
      SPB_IDLE = 2'b00,
      SPB_LOAD = 2'b01,
      SPB_SHIFT = 2'b11,
      SPB_DONE = 2'b10
   } spb_state_e;

   typedef struct packed {
      logic extra_double_rate;
      logic double_rate;
      logic baud_timer_prescale_select;
      logic timer_source_select;
      logic use_dedicated_timer;
      logic timer_x12_select;
      logic [7:0] dedicated_baud_reload;
      logic [7:0] reload_high_byte;
      logic [7:0] reload_low_byte;
   } spb_baud_cfg_s;
endpackage

// File: core/spb_fifo.sv
/*
 Byte FIFO between serial buffer writes and the shift engine.
 Assumes the drain side may stall; read data come from a register.
*/
`timescale 1ns/1ps
`default_nettype none
module spb_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 8
) (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [W-1:0] out_data_o,
   input wire logic out_ready_i
);
   localparam int unsigned AW = $clog2(D);
   localparam logic [AW:0] FULL = (AW+1)'(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [W-1:0] dout;
      logic ov;
      logic rdy;
   } spb_fifo_s;

   spb_fifo_s s_ff, nxt_s;

   always_comb begin
      nxt_s = s_ff;
      if (s_ff.ov && out_ready_i) begin
         nxt_s.ov = 1'b0;
      end
      if ((!s_ff.ov || out_ready_i) && (s_ff.wp != s_ff.rp)) begin
         nxt_s.dout = s_ff.mem[s_ff.rp[AW-1:0]];
         nxt_s.rp = s_ff.rp + 1'b1;
         nxt_s.ov = 1'b1;
      end
      if (in_valid_i && s_ff.rdy) begin
         nxt_s.mem[s_ff.wp[AW-1:0]] = in_data_i;
         nxt_s.wp = s_ff.wp + 1'b1;
      end
      nxt_s.rdy = (nxt_s.wp - nxt_s.rp) != FULL;
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         s_ff <= '0;
         s_ff.rdy <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign in_ready_o = s_ff.rdy;
   assign out_valid_o = s_ff.ov;
   assign out_data_o = s_ff.dout;
endmodule
`default_nettype wire

// File: core/spb_baud.sv
/*
 Baud tick source for the UART modes: dedicated 8-bit timer, 16-bit reload
 timer or the second port's tick. Assumes configuration is static while used.
*/
`timescale 1ns/1ps
`default_nettype none
module spb_baud (
   input wire logic clock_i,
   input wire logic reset_i,
   input wire spb_pkg::spb_baud_cfg_s cfg_i,
   input wire logic second_port_baud_tick_i,
   output logic baud_tick_o
);
   typedef struct packed {
      logic [3:0] pre;
      logic pre16;
      logic [7:0] t8;
      logic [15:0] t16;
      logic [5:0] div;
      logic tick;
   } spb_baud_s;

   spb_baud_s s_ff, nxt_s;
   logic step8, step16, ovf8, ovf16, src;
   logic [5:0] target;

   always_comb begin
      nxt_s = s_ff;
      ovf8 = 1'b0;
      ovf16 = 1'b0;
      // Prescale 1 or 12 on the dedicated timer
      step8 = cfg_i.baud_timer_prescale_select
         || (s_ff.pre == spb_pkg::PRESCALE_SLOW - 4'h1);
      nxt_s.pre = step8 ? 4'h0 : s_ff.pre + 4'h1;
      // Timers count the reload distance, so a new reload acts within one period
      if (step8) begin
         if (s_ff.t8 >= spb_pkg::RELOAD8_TOP - cfg_i.dedicated_baud_reload) begin
            nxt_s.t8 = 8'h0;
            ovf8 = 1'b1;
         end else begin
            nxt_s.t8 = s_ff.t8 + 8'h1;
         end
      end
      step16 = cfg_i.timer_x12_select || s_ff.pre16;
      nxt_s.pre16 = ~s_ff.pre16;
      if (step16) begin
         if (s_ff.t16 >= spb_pkg::RELOAD16_TOP
               - {cfg_i.reload_high_byte, cfg_i.reload_low_byte}) begin
            nxt_s.t16 = 16'h0;
            ovf16 = 1'b1;
         end else begin
            nxt_s.t16 = s_ff.t16 + 16'h1;
         end
      end
      if (cfg_i.timer_source_select) begin
         src = second_port_baud_tick_i;
         target = spb_pkg::BAUD8_DIV >>
            ({1'b0, cfg_i.extra_double_rate} + {1'b0, cfg_i.double_rate});
      end else if (cfg_i.use_dedicated_timer) begin
         src = ovf8;
         target = spb_pkg::BAUD8_DIV >>
            ({1'b0, cfg_i.extra_double_rate} + {1'b0, cfg_i.double_rate});
      end else begin
         src = ovf16;
         target = spb_pkg::BAUD16_DIV >> ({1'b0, cfg_i.extra_double_rate}
            + {1'b0, cfg_i.extra_double_rate & cfg_i.double_rate});
      end
      nxt_s.tick = 1'b0;
      if (src) begin
         if (s_ff.div >= target - 6'h1) begin
            nxt_s.div = 6'h0;
            nxt_s.tick = 1'b1;
         end else begin
            nxt_s.div = s_ff.div + 6'h1;
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign baud_tick_o = s_ff.tick;
endmodule
`default_nettype wire

// File: sim/spb_slave_model.sv
/*
 Behavioural SPI slave that answers the serial port in SPI master mode.
 Assumes the bench drives its select, clock polarity, bit order and reply byte.
*/
`timescale 1ns/1ps
`default_nettype none
module spb_slave_model (
   input wire logic sclk_i,
   input wire logic mosi_i,
   input wire logic cpol_i,
   input wire logic lsb_first_i,
   input wire logic sel_n_i,
   input wire logic [7:0] tx_byte_i,
   output logic miso_o,
   output logic [7:0] rx_byte_o,
   output var int byte_cnt_o
);
   int idx;
   logic [7:0] sh;
   initial begin
      idx = 0;
      sh = 8'h00;
      miso_o = 1'b0;
      rx_byte_o = 8'h00;
      byte_cnt_o = 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Bit counter restarts on each selection
   always @(negedge sel_n_i) idx = 0;
   // Leading edge captures data out, trailing edge moves to the next bit
   always @(sclk_i) begin
      if (sel_n_i === 1'b0) begin
         if (sclk_i !== cpol_i) begin
            sh[lsb_first_i ? idx : 7 - idx] = mosi_i;
         end else begin
            idx = idx + 1;
            if (idx == 8) begin
               idx = 0;
               rx_byte_o = sh;
               byte_cnt_o = byte_cnt_o + 1;
            end
         end
      end
   end
   // Deselected line does not hold its last value
   always @(sel_n_i or idx or tx_byte_i or lsb_first_i) begin
      if (sel_n_i === 1'b0) begin
         miso_o = tx_byte_i[lsb_first_i ? idx : 7 - idx];
      end else begin
         miso_o = ~miso_o;
      end
   end
endmodule
`default_nettype wire

// File: sim/spb_top_tb.sv
/*
 Self-checking bench for the serial port: mode decode, SPI transfers, FIFO, baud ticks.
 Assumes the design in core/ and the slave model in sim/.
*/
`timescale 1ns/1ps
`default_nettype none
module spb_top_tb;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic mhi = 1'b0, mmid = 1'b0, mlo = 1'b0, speed = 1'b0, order = 1'b1, cpol = 1'b0;
   logic wr = 1'b0, fclr = 1'b0, sp_tick = 1'b0, sel_n = 1'b1;
   logic [7:0] wdata = 8'h00, stx = 8'h00;
   spb_pkg::spb_baud_cfg_s baud = '0;
   logic ready, tdone, rdone, rsv, busy, txp, txoe, rxp, rxoe, btick, miso;
   logic [7:0] sbuf, rx;
   logic [2:0] mode;
   wire logic sclk_w = txoe ? txp : cpol;
   wire logic mosi_w = rxoe ? rxp : 1'b1;
   int bcnt, error_cnt = 0, checks_done = 0, cycles = 0;

   spb_top u_dut (.clock_i(clock_i), .reset_i(reset_i), .mode_select_high_i(mhi),
      .mode_select_mid_i(mmid), .mode_select_low_i(mlo), .shift_speed_select_i(speed),
      .bit_order_select_i(order), .tx_latch_level_i(cpol), .buf_wr_i(wr),
      .buf_wr_data_i(wdata), .flag_clear_i(fclr), .master_in_pin_i(miso),
      .baud_cfg_i(baud), .second_port_baud_tick_i(sp_tick), .buf_wr_ready_o(ready),
      .serial_buffer_o(sbuf), .transmit_done_flag_o(tdone), .receive_done_flag_o(rdone),
      .mode_o(mode), .mode_reserved_o(rsv), .busy_o(busy), .port_tx_pin_o(txp),
      .port_tx_pin_oe_o(txoe), .port_rx_pin_o(rxp), .port_rx_pin_oe_o(rxoe),
      .uart_baud_tick_o(btick));

   spb_slave_model u_slave (.sclk_i(sclk_w), .mosi_i(mosi_w), .cpol_i(cpol),
      .lsb_first_i(order), .sel_n_i(sel_n), .tx_byte_i(stx), .miso_o(miso),
      .rx_byte_o(rx), .byte_cnt_o(bcnt));

   always #10 clock_i = ~clock_i;
   ////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task chk1(input logic a, input logic e);
      checks_done++;
      if (a !== e) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task chk8(input logic [7:0] a, input logic [7:0] e);
      checks_done++;
      if (a !== e) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task chkn(input int a, input int e);
      checks_done++;
      if (a != e) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, a, e);
      end
   endtask
   task test_done;
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         $display("FAIL at %0t: got %h expected %h", $time, cycles, 0);
         test_done;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Access tasks
   task cyc(input int n);
      repeat (n) begin
         @(posedge clock_i);
         #1;
      end
   endtask
   task set_mode(input logic [2:0] c);
      {mhi, mmid, mlo} = c;
      cyc(2);
   endtask
   task wr_byte(input logic [7:0] d);
      int n;
      n = 0;
      wr = 1'b1;
      wdata = d;
      while (ready !== 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      cyc(1);
      wr = 1'b0;
   endtask
   task xfer(input logic [7:0] d, input logic [7:0] s, input logic sp, input logic od,
      input logic pol);
      int n, lead, t1, t2;
      logic prev;
      speed = sp;
      order = od;
      cpol = pol;
      stx = s;
      cyc(2);
      chk1(txp, pol);
      sel_n = 1'b0;
      cyc(1);
      wr_byte(d);
      n = 0;
      lead = 0;
      t1 = 0;
      t2 = 0;
      prev = txp;
      while (tdone !== 1'b1 && n < 400) begin
         cyc(1);
         n++;
         if (txp !== prev && txp !== pol) begin
            lead++;
            if (lead == 1) t1 = n;
            if (lead == 2) t2 = n;
         end
         prev = txp;
      end
      chkn(lead, 8);
      chkn(t2 - t1, sp ? 4 : 12);
      chk8(rx, d);
      chk8(sbuf, s);
      chk1(rdone, 1'b0);
      chk1(busy, 1'b0);
      cyc(30);
      chk1(tdone, 1'b1);
      fclr = 1'b1;
      cyc(1);
      fclr = 1'b0;
      cyc(1);
      chk1(tdone, 1'b0);
      sel_n = 1'b1;
   endtask
   task tick_period(input int e);
      int n;
      n = 0;
      cyc(70);
      while (btick !== 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      cyc(1);
      n = 1;
      while (btick !== 1'b1 && n < 500) begin
         cyc(1);
         n++;
      end
      chkn(n, e);
   endtask
   task count_ticks(output int t);
      t = 0;
      repeat (200) begin
         cyc(1);
         if (btick === 1'b1) t++;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      int acc, b0, n;
      cyc(10);
      reset_i = 1'b0;
      cyc(1);
      chk1(ready, 1'b1);
      chk1(tdone, 1'b0);
      chk1(busy, 1'b0);
      chk8(sbuf, 8'h00);
      for (int c = 0; c < 8; c++) begin
         set_mode(c[2:0]);
         chk8({5'h00, mode}, c[7:0]);
         chk1(rsv, c >= 5);
         chk1(txoe, c == 4);
         chk1(rxoe, c == 4);
      end
      set_mode(3'h4);
      for (int k = 0; k < 8; k++) begin
         xfer(8'h35 + 8'(k * 37), 8'hc1 ^ 8'(k * 13), k[0], k[1], k[2]);
      end
      // Leaving the mode mid-transfer gives no flag
      sel_n = 1'b0;
      wr_byte(8'h5a);
      cyc(20);
      set_mode(3'h0);
      cyc(200);
      chk1(tdone, 1'b0);
      chk1(busy, 1'b0);
      sel_n = 1'b1;
      // Queue while not in SPI mode until refused, then drain back to back
      speed = 1'b1;
      order = 1'b1;
      cpol = 1'b0;
      acc = 0;
      wr = 1'b1;
      for (int i = 0; i < 16; i++) begin
         wdata = 8'h10 + 8'(i);
         if (ready !== 1'b1) break;
         acc++;
         cyc(1);
      end
      wr = 1'b0;
      chk1(ready, 1'b0);
      chkn(acc, spb_pkg::FIFO_DEPTH + 1);
      cyc(2);
      sel_n = 1'b0;
      stx = 8'ha5;
      b0 = bcnt;
      set_mode(3'h4);
      n = 0;
      while ((bcnt - b0 < acc || busy === 1'b1) && n < 3000) begin
         cyc(1);
         n++;
      end
      chkn(bcnt - b0, acc);
      chk8(rx, 8'h10 + 8'(acc - 1));
      chk1(tdone, 1'b1);
      sel_n = 1'b1;
      // Baud sources in mode 1
      set_mode(3'h1);
      baud.use_dedicated_timer = 1'b1;
      baud.baud_timer_prescale_select = 1'b1;
      baud.dedicated_baud_reload = 8'hff;
      tick_period(32);
      baud.extra_double_rate = 1'b1;
      tick_period(16);
      baud.double_rate = 1'b1;
      tick_period(8);
      baud = '0;
      baud.timer_x12_select = 1'b1;
      baud.reload_high_byte = 8'hff;
      baud.reload_low_byte = 8'hff;
      tick_period(16);
      baud.extra_double_rate = 1'b1;
      tick_period(8);
      baud = '0;
      baud.use_dedicated_timer = 1'b1;
      baud.baud_timer_prescale_select = 1'b1;
      baud.dedicated_baud_reload = 8'hff;
      baud.timer_source_select = 1'b1;
      cyc(5);
      count_ticks(n);
      chkn(n, 0);
      sp_tick = 1'b1;
      count_ticks(n);
      chk1(n > 0, 1'b1);
      test_done;
   end
endmodule
`default_nettype wire
